// ---- include/adcr_pkg.sv ----
// Package with register codes, field layout, reset values and types of the converter result registers.
package adcr_pkg;

  // Geometry of the block.
  localparam int unsigned PORTS   = 4;
  localparam int unsigned KINDS   = 3;
  localparam int unsigned RES_W   = 15;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned WORD_W  = RES_W + 1;
  localparam int unsigned PSEL_W  = 2;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned KIND_W  = 2;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Register select codes, one set per port.
  localparam logic [SEL_W-1:0] SEL_VOLTAGE_RESULT_LOW      = 4'h8;
  localparam logic [SEL_W-1:0] SEL_VOLTAGE_RESULT_HIGH     = 4'h9;
  localparam logic [SEL_W-1:0] SEL_CURRENT_RESULT_LOW      = 4'hA;
  localparam logic [SEL_W-1:0] SEL_CURRENT_RESULT_HIGH     = 4'hB;
  localparam logic [SEL_W-1:0] SEL_TEMPERATURE_RESULT_LOW  = 4'hC;
  localparam logic [SEL_W-1:0] SEL_TEMPERATURE_RESULT_HIGH = 4'hD;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Field layout of the low and high result registers.
  localparam int unsigned LOW_MSB   = 7;
  localparam int unsigned HIGH_LSB  = 8;
  localparam int unsigned HIGH_MSB  = 14;
  localparam int unsigned FLAG_BIT  = 15;
  localparam logic [BYTE_W-1:0] READ_UNMAPPED = 8'h00;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Quantity codes carried with a conversion start, also the channel index.
  localparam logic [KIND_W-1:0] KIND_VOLTAGE     = 2'h0;
  localparam logic [KIND_W-1:0] KIND_CURRENT     = 2'h1;
  localparam logic [KIND_W-1:0] KIND_TEMPERATURE = 2'h2;

  typedef enum logic {
    ADCR_IDLE,
    ADCR_BUSY
  } adcr_state_e;

  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } adcr_chan_s;

  typedef struct packed {
    adcr_state_e       state;
    logic [KIND_W-1:0] kind;
  } adcr_port_s;

  typedef struct packed {
    adcr_port_s [PORTS-1:0] port;
  } adcr_top_s;

  typedef struct packed {
    logic [BYTE_W-1:0] rd_data;
    logic              rd_valid;
    logic              wr_done;
  } adcr_regs_s;

  localparam adcr_chan_s CHAN_RESET = '{done: 1'h0, result: 15'h0000};
  localparam adcr_port_s PORT_RESET = '{state: ADCR_IDLE, kind: 2'h0};
  localparam adcr_regs_s REGS_RESET = '{rd_data: 8'h00, rd_valid: 1'h0, wr_done: 1'h0};

endpackage : adcr_pkg

// ---- include/adcr_res_if.sv ----
// Interface that joins the sequencer to one result channel.
`timescale 1ns/1ns
`default_nettype none

interface adcr_res_if;
  logic                       start;
  logic                       finish;
  logic [adcr_pkg::RES_W-1:0] data;
  logic [adcr_pkg::RES_W-1:0] result;
  logic                       done;

  modport ctrl (output start, output finish, output data, input result, input done);
  modport chan (input start, input finish, input data, output result, output done);
endinterface : adcr_res_if

`default_nettype wire

// ---- design/adcr_chan.sv ----
// One result channel: the 15-bit result and its completion flag.
`timescale 1ns/1ns
`default_nettype none

module adcr_chan (
  input wire logic clk,
  input wire logic reset,
  adcr_res_if.chan link
);
  import adcr_pkg::*;

  adcr_chan_s s_q;
  adcr_chan_s s_d;

  always_comb begin
    s_d = s_q;
    if (link.finish) begin
      s_d.result = link.data;
      s_d.done   = 1'h1;
    end
    // A new start in the same cycle leaves the flag low, as the new conversion is running.
    if (link.start) begin
      s_d.done = 1'h0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= CHAN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.result = s_q.result;
  assign link.done   = s_q.done;

endmodule : adcr_chan

`default_nettype wire

// ---- design/adcr_regport.sv ----
// Host register port: read decode of the result registers, writes acknowledged and dropped.
`timescale 1ns/1ns
`default_nettype none

module adcr_regport (
  input  wire logic                                                            clk,
  input  wire logic                                                            reset,
  input  wire logic                                                            rd,
  input  wire logic                                                            wr,
  input  wire logic [adcr_pkg::PSEL_W-1:0]                                     port_sel,
  input  wire logic [adcr_pkg::SEL_W-1:0]                                      reg_sel,
  input  wire logic [adcr_pkg::PORTS-1:0][adcr_pkg::KINDS-1:0][adcr_pkg::WORD_W-1:0] words,
  output logic      [adcr_pkg::BYTE_W-1:0]                                     rd_data,
  output logic                                                                 rd_valid,
  output logic                                                                 wr_done
);
  import adcr_pkg::*;

  adcr_regs_s s_q;
  adcr_regs_s s_d;
  logic [KINDS-1:0][WORD_W-1:0] sel_words;

  assign sel_words = words[port_sel];

  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = rd;
    // Writes change nothing; they are only acknowledged.
    s_d.wr_done  = wr;
    if (rd) begin
      if (reg_sel == SEL_VOLTAGE_RESULT_LOW) begin
        s_d.rd_data = sel_words[KIND_VOLTAGE][LOW_MSB:0];
      end else if (reg_sel == SEL_VOLTAGE_RESULT_HIGH) begin
        s_d.rd_data = {sel_words[KIND_VOLTAGE][FLAG_BIT], sel_words[KIND_VOLTAGE][HIGH_MSB:HIGH_LSB]};
      end else if (reg_sel == SEL_CURRENT_RESULT_LOW) begin
        s_d.rd_data = sel_words[KIND_CURRENT][LOW_MSB:0];
      end else if (reg_sel == SEL_CURRENT_RESULT_HIGH) begin
        s_d.rd_data = {sel_words[KIND_CURRENT][FLAG_BIT], sel_words[KIND_CURRENT][HIGH_MSB:HIGH_LSB]};
      end else if (reg_sel == SEL_TEMPERATURE_RESULT_LOW) begin
        s_d.rd_data = sel_words[KIND_TEMPERATURE][LOW_MSB:0];
      end else if (reg_sel == SEL_TEMPERATURE_RESULT_HIGH) begin
        s_d.rd_data = {sel_words[KIND_TEMPERATURE][FLAG_BIT],
                       sel_words[KIND_TEMPERATURE][HIGH_MSB:HIGH_LSB]};
      end else begin
        s_d.rd_data = READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data  = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign wr_done  = s_q.wr_done;

endmodule : adcr_regport

`default_nettype wire

// ---- design/adcr_top.sv ----
// Converter result registers for four ports: conversion sequencing, result channels and host port.
//
// Overview of operation
// - Select code 1000 of each port reads voltage result bits 7 to 0 with bit 0 in D0.
// - Select code 1001 reads voltage result bits 14 to 8 in D6 to D0, with the completion flag in D7.
// - The voltage completion flag falls when a voltage conversion starts and rises when it finishes.
// - Select code 1010 reads current result bits 7 to 0.
// - Select code 1011 reads current result bits 14 to 8 in D6 to D0, with the completion flag in D7.
// - The current completion flag falls when a current conversion starts and rises when it finishes.
// - Select code 1100 reads temperature result bits 7 to 0.
// - Select code 1101 reads temperature result bits 14 to 8 in D6 to D0, with the completion flag in D7.
// - The temperature completion flag falls when a temperature conversion starts and rises when it finishes.
`timescale 1ns/1ns
`default_nettype none

module adcr_top (
  input  wire logic                                              clk,
  input  wire logic                                              reset,
  input  wire logic [adcr_pkg::PORTS-1:0]                        adc_start,
  input  wire logic [adcr_pkg::PORTS-1:0][adcr_pkg::KIND_W-1:0]  adc_kind,
  input  wire logic [adcr_pkg::PORTS-1:0]                        adc_abort,
  input  wire logic [adcr_pkg::PORTS-1:0]                        adc_finish,
  input  wire logic [adcr_pkg::PORTS-1:0][adcr_pkg::RES_W-1:0]   adc_result,
  output logic      [adcr_pkg::PORTS-1:0]                        adc_active,
  input  wire logic                                              host_rd,
  input  wire logic                                              host_wr,
  input  wire logic [adcr_pkg::PSEL_W-1:0]                       host_port_sel,
  input  wire logic [adcr_pkg::SEL_W-1:0]                        host_reg_sel,
  input  wire logic [adcr_pkg::BYTE_W-1:0]                       host_wr_data,
  output logic      [adcr_pkg::BYTE_W-1:0]                       host_rd_data,
  output logic                                                   host_rd_valid,
  output logic                                                   host_wr_done
);
  import adcr_pkg::*;

  adcr_top_s s_q;
  adcr_top_s s_d;

  logic [PORTS-1:0]                   start_ok;
  logic [PORTS-1:0]                   finish_ok;
  logic [PORTS-1:0][KINDS-1:0]        chan_start;
  logic [PORTS-1:0][KINDS-1:0]        chan_finish;
  logic [PORTS-1:0][KINDS-1:0][WORD_W-1:0] words;
  logic [BYTE_W-1:0]                  wr_data_unused;

  // Write data has no destination: the result registers are read-only.
  assign wr_data_unused = host_wr_data;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Per-port sequencing: a start names the quantity, the finish lands on the quantity that started.

  always_comb begin
    s_d = s_q;
    for (int p = 0; p < PORTS; p++) begin
      start_ok[p]  = adc_start[p] && (adc_kind[p] == KIND_VOLTAGE || adc_kind[p] == KIND_CURRENT ||
                                      adc_kind[p] == KIND_TEMPERATURE);
      finish_ok[p] = (s_q.port[p].state == ADCR_BUSY) && adc_finish[p] && !adc_abort[p];
      case (s_q.port[p].state)
        ADCR_IDLE: begin
          if (start_ok[p]) begin
            s_d.port[p].state = ADCR_BUSY;
            s_d.port[p].kind  = adc_kind[p];
          end
        end
        ADCR_BUSY: begin
          if (start_ok[p]) begin
            s_d.port[p].kind = adc_kind[p];
          end else if (adc_finish[p] || adc_abort[p]) begin
            s_d.port[p].state = ADCR_IDLE;
          end
        end
        default: begin
          s_d.port[p] = PORT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < PORTS; p++) begin
        s_q.port[p] <= PORT_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Result channels, three per port.

  genvar gp;
  genvar gk;
  generate
    for (gp = 0; gp < PORTS; gp++) begin : g_port
      assign adc_active[gp] = (s_q.port[gp].state == ADCR_BUSY);
      for (gk = 0; gk < KINDS; gk++) begin : g_kind
        adcr_res_if link ();

        assign chan_start[gp][gk]  = start_ok[gp] && (adc_kind[gp] == KIND_W'(gk));
        assign chan_finish[gp][gk] = finish_ok[gp] && (s_q.port[gp].kind == KIND_W'(gk));
        assign link.start          = chan_start[gp][gk];
        assign link.finish         = chan_finish[gp][gk];
        assign link.data           = adc_result[gp];
        assign words[gp][gk]       = {link.done, link.result};

        adcr_chan u_chan (
          .clk   (clk),
          .reset (reset),
          .link  (link)
        );
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Host access to the result registers.

  adcr_regport u_regport (
    .clk      (clk),
    .reset    (reset),
    .rd       (host_rd),
    .wr       (host_wr),
    .port_sel (host_port_sel),
    .reg_sel  (host_reg_sel),
    .words    (words),
    .rd_data  (host_rd_data),
    .rd_valid (host_rd_valid),
    .wr_done  (host_wr_done)
  );

endmodule : adcr_top

`default_nettype wire

// ---- bench/adcr_top_asserts.sv ----
// Concurrent checks on the ports of the converter result register block.
`timescale 1ns/1ns
`default_nettype none
module adcr_top_asserts (
  input wire logic                                             clk,
  input wire logic                                             reset,
  input wire logic [adcr_pkg::PORTS-1:0]                       adc_start,
  input wire logic [adcr_pkg::PORTS-1:0][adcr_pkg::KIND_W-1:0] adc_kind,
  input wire logic [adcr_pkg::PORTS-1:0]                       adc_abort,
  input wire logic [adcr_pkg::PORTS-1:0]                       adc_finish,
  input wire logic [adcr_pkg::PORTS-1:0]                       adc_active,
  input wire logic                                             host_rd,
  input wire logic                                             host_wr,
  input wire logic [adcr_pkg::PSEL_W-1:0]                      host_port_sel,
  input wire logic [adcr_pkg::SEL_W-1:0]                       host_reg_sel,
  input wire logic [adcr_pkg::BYTE_W-1:0]                      host_rd_data,
  input wire logic                                             host_rd_valid,
  input wire logic                                             host_wr_done
);
  import adcr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_rd_answer: assert property (host_rd |=> host_rd_valid) else $error("read not answered");
  a_rd_cause: assert property (host_rd_valid |-> $past(host_rd)) else $error("spurious read valid");
  a_wr_answer: assert property (host_wr |=> host_wr_done) else $error("write not acknowledged");
  a_wr_cause: assert property (host_wr_done |-> $past(host_wr)) else $error("spurious write done");
  a_data_holds: assert property (!host_rd_valid |-> $stable(host_rd_data)) else $error("read data moved");
  a_unmapped_zero: assert property (host_rd && (host_reg_sel < 4'h8 || host_reg_sel > 4'hD)
    |=> host_rd_data == READ_UNMAPPED) else $error("unmapped code not zero");
  a_flag_clear: assert property ($past(adc_start[0] && adc_kind[0] != 2'h3) && host_rd && host_port_sel == 2'h0
    && host_reg_sel == {1'b1, $past(adc_kind[0]), 1'b1} |=> !host_rd_data[7]) else $error("flag not cleared");
  a_active_start: assert property (adc_start[0] && adc_kind[0] != 2'h3 |=> adc_active[0]) else $error("no start");
  a_active_end: assert property (adc_active[0] && (adc_finish[0] || adc_abort[0]) && !adc_start[0]
    |=> !adc_active[0]) else $error("conversion did not end");
endmodule : adcr_top_asserts
bind adcr_top adcr_top_asserts u_asserts (.clk(clk), .reset(reset), .adc_start(adc_start), .adc_kind(adc_kind),
  .adc_abort(adc_abort), .adc_finish(adc_finish), .adc_active(adc_active), .host_rd(host_rd), .host_wr(host_wr),
  .host_port_sel(host_port_sel), .host_reg_sel(host_reg_sel), .host_rd_data(host_rd_data),
  .host_rd_valid(host_rd_valid), .host_wr_done(host_wr_done));
`default_nettype wire

// ---- bench/adcr_conv_model.sv ----
// Behavioural converter front end that starts, finishes or aborts one conversion, or finishes one in the cycle that starts the next.
`timescale 1ns/1ns
`default_nettype none
module adcr_conv_model (
  input wire logic                                        clk,
  output logic [adcr_pkg::PORTS-1:0]                      adc_start,
  output logic [adcr_pkg::PORTS-1:0][adcr_pkg::KIND_W-1:0] adc_kind,
  output logic [adcr_pkg::PORTS-1:0]                      adc_abort,
  output logic [adcr_pkg::PORTS-1:0]                      adc_finish,
  output logic [adcr_pkg::PORTS-1:0][adcr_pkg::RES_W-1:0]  adc_result
);
  import adcr_pkg::*;
  initial begin
    {adc_start, adc_abort, adc_finish, adc_result} = '0;
    adc_kind = '1;
  end
  task automatic convert(input int p, input logic [KIND_W-1:0] k, input logic [RES_W-1:0] v, input int n,
                         input bit ab);
    @(posedge clk);
    adc_start[p] <= 1'b1;
    adc_kind[p]  <= k;
    @(posedge clk);
    adc_start[p] <= 1'b0;
    repeat (n) @(posedge clk);
    adc_abort[p]  <= ab;
    adc_finish[p] <= !ab;
    adc_result[p] <= v;
    @(posedge clk);
    adc_abort[p]  <= 1'b0;
    adc_finish[p] <= 1'b0;
    // The result lines carry a different value outside the finish cycle so a late sample shows up.
    adc_result[p] <= ~v;
  endtask : convert
  // Starts kind k1, then finishes it in the same cycle that starts kind k2, leaving the port busy with k2.
  task automatic overlap(input int p, input logic [KIND_W-1:0] k1, input logic [KIND_W-1:0] k2,
                         input logic [RES_W-1:0] v);
    @(posedge clk);
    adc_start[p] <= 1'b1;
    adc_kind[p]  <= k1;
    @(posedge clk);
    adc_start[p] <= 1'b0;
    @(posedge clk);
    adc_start[p]  <= 1'b1;
    adc_kind[p]   <= k2;
    adc_finish[p] <= 1'b1;
    adc_result[p] <= v;
    @(posedge clk);
    adc_start[p]  <= 1'b0;
    adc_finish[p] <= 1'b0;
    adc_result[p] <= ~v;
  endtask : overlap
endmodule : adcr_conv_model
`default_nettype wire

// ---- bench/adc_result_registers_tb_top.sv ----
// Self-checking bench for the converter result registers.
`timescale 1ns/1ns
`default_nettype none
module adc_result_registers_tb_top;
  import adcr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [PSEL_W-1:0] host_port_sel = '0;
  logic [SEL_W-1:0] host_reg_sel = '0;
  logic [BYTE_W-1:0] host_wr_data = '0;
  logic [BYTE_W-1:0] host_rd_data;
  logic host_rd_valid;
  logic host_wr_done;
  logic [PORTS-1:0] adc_start, adc_abort, adc_finish, adc_active;
  logic [PORTS-1:0][KIND_W-1:0] adc_kind;
  logic [PORTS-1:0][RES_W-1:0] adc_result;
  logic [PORTS-1:0][KINDS-1:0][RES_W-1:0] res = '0;
  logic [PORTS-1:0][KINDS-1:0] flg = '0;
  logic [BYTE_W-1:0] rq[$];
  int wq, fails, n_checks, cyc, seed;
  adcr_top dut (.clk(clk), .reset(reset), .adc_start(adc_start), .adc_kind(adc_kind), .adc_abort(adc_abort),
    .adc_finish(adc_finish), .adc_result(adc_result), .adc_active(adc_active), .host_rd(host_rd),
    .host_wr(host_wr), .host_port_sel(host_port_sel), .host_reg_sel(host_reg_sel), .host_wr_data(host_wr_data),
    .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid), .host_wr_done(host_wr_done));
  adcr_conv_model u_conv (.clk(clk), .adc_start(adc_start), .adc_kind(adc_kind), .adc_abort(adc_abort),
    .adc_finish(adc_finish), .adc_result(adc_result));
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (rq.size() != 0 || wq != 0) fails++;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic rd(input int p, input logic [SEL_W-1:0] s);
    logic [BYTE_W-1:0] e;
    e = READ_UNMAPPED;
    if (s >= SEL_VOLTAGE_RESULT_LOW && s <= SEL_TEMPERATURE_RESULT_HIGH)
      e = s[0] ? {flg[p][s[2:1]], res[p][s[2:1]][14:8]} : res[p][s[2:1]][7:0];
    @(posedge clk);
    host_rd <= 1'b1;
    host_port_sel <= p[PSEL_W-1:0];
    host_reg_sel <= s;
    rq.push_back(e);
    @(posedge clk);
    host_rd <= 1'b0;
  endtask : rd
  task automatic wr(input int p, input logic [SEL_W-1:0] s);
    @(posedge clk);
    host_wr <= 1'b1;
    host_port_sel <= p[PSEL_W-1:0];
    host_reg_sel <= s;
    host_wr_data <= BYTE_W'($urandom);
    wq++;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask : wr
  task automatic conv(input int p, input logic [KIND_W-1:0] k, input int n, input bit ab);
    logic [RES_W-1:0] v;
    v = RES_W'($urandom);
    if (k != 2'h3) flg[p][k] = 1'b0;
    u_conv.convert(p, k, v, n, ab);
    if (!ab && k != 2'h3) begin
      res[p][k] = v;
      flg[p][k] = 1'b1;
    end
  endtask : conv
  // The old kind completes with v; the new kind's flag ends low, also when both kinds are the same.
  task automatic pair(input int p, input int k1, input int k2);
    logic [RES_W-1:0] v;
    v = RES_W'($urandom);
    u_conv.overlap(p, k1[KIND_W-1:0], k2[KIND_W-1:0], v);
    res[p][k1] = v;
    flg[p][k1] = 1'b1;
    flg[p][k2] = 1'b0;
    rd(p, {1'b1, k1[1:0], 1'b0});
    rd(p, {1'b1, k1[1:0], 1'b1});
    rd(p, {1'b1, k2[1:0], 1'b1});
  endtask : pair
  task automatic check_rd();
    logic [BYTE_W-1:0] e;
    e = rq.size() != 0 ? rq.pop_front() : 'x;
    n_checks++;
    if (host_rd_data !== e) begin
      fails++;
      $display("mismatch at %0t: read %h expected %h", $time, host_rd_data, e);
    end
  endtask : check_rd
  task automatic check_wr();
    n_checks++;
    if (wq == 0) begin
      fails++;
      $display("mismatch at %0t: unrequested write acknowledge", $time);
    end else wq--;
  endtask : check_wr
  ////////////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (host_rd_valid === 1'b1) check_rd();
    if (host_wr_done === 1'b1) check_wr();
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    seed = $urandom(60);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int s = 0; s < 16; s++) rd(0, s[3:0]);
    $display("test reset_values done");
    for (int p = 0; p < PORTS; p++) begin
      for (int k = 0; k < KINDS; k++) begin
        conv(p, k[1:0], 1 + $urandom % 4, 1'b0);
        rd(p, {1'b1, k[1:0], 1'b0});
        rd(p, {1'b1, k[1:0], 1'b1});
      end
    end
    $display("test all_results done");
    for (int k = 0; k < KINDS; k++) begin
      fork
        conv(0, k[1:0], 5, 1'b0);
        begin
          @(posedge clk);
          rd(0, {1'b1, k[1:0], 1'b1});
        end
      join
      rd(0, {1'b1, k[1:0], 1'b1});
    end
    $display("test flag_active done");
    conv(0, KIND_VOLTAGE, 3, 1'b1);
    rd(0, SEL_VOLTAGE_RESULT_LOW);
    rd(0, SEL_VOLTAGE_RESULT_HIGH);
    conv(1, 2'h3, 2, 1'b0);
    for (int s = 8; s < 14; s++) rd(1, s[3:0]);
    $display("test abort_and_bad_kind done");
    for (int j = 0; j < 2 * KINDS; j++) begin
      pair(3, j % KINDS, j < KINDS ? j : (j + 1) % KINDS);
    end
    $display("test start_with_finish done");
    for (int s = 8; s < 14; s++) begin
      wr(2, s[3:0]);
      rd(2, s[3:0]);
    end
    $display("test read_only done");
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : adc_result_registers_tb_top
`default_nettype wire
